// ---- apc_regs.sv ----
`timescale 1ns/10ps
module apc_regs #(
  // level of the rc clock power-down after reset; the analog side treats it as unknown
  parameter logic RC_PD_RESET = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic rx_line_reset,
  input wire logic soft_reset,
  input wire logic sleep_mode,
  input wire logic current_detect_mode,
  input wire logic [apc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [apc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [apc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [apc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic rc_clock_powerdown,
  output logic bias_enable,
  output logic reference_enable,
  output logic voltage_adc_enable,
  output logic [31:0] analog_control_one,
  output logic [31:0] analog_control_two
);

  typedef struct packed {
    logic aw_full;
    logic [9:0] aw_idx;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] ctrl_zero;
    logic [31:0] ctrl_one;
    logic [31:0] ctrl_two;
  } apc_state_t;

  apc_state_t s_q;
  apc_state_t s_d;
  logic sleep_entry;
  logic detect_entry;

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction : apply_strb

  function automatic logic is_mapped(input logic [9:0] idx);
    return (idx == apc_pkg::IDX_CTRL_ZERO) || (idx == apc_pkg::IDX_CTRL_ONE)
        || (idx == apc_pkg::IDX_CTRL_TWO);
  endfunction : is_mapped

  function automatic logic [31:0] reset_zero();
    logic [31:0] v;
    v = apc_pkg::RST_CTRL_ZERO;
    v[apc_pkg::BIT_RC_CLOCK_POWERDOWN] = RC_PD_RESET; // R5
    return v;
  endfunction : reset_zero

  apc_mode_edge u_mode_edge (
    .clk(clk),
    .rst(rst),
    .sleep_mode(sleep_mode),
    .current_detect_mode(current_detect_mode),
    .sleep_entry(sleep_entry),
    .detect_entry(detect_entry)
  );

  assign s_axi_awready = ~s_q.aw_full;
  assign s_axi_wready = ~s_q.w_full;
  assign s_axi_arready = ~s_q.rvalid;

  always_comb begin
    s_d = s_q;
    // address and data may arrive in either order; each is held until both are in
    if (s_axi_awvalid && !s_q.aw_full) begin
      s_d.aw_full = 1'b1;
      s_d.aw_idx = s_axi_awaddr[11:2];
    end
    if (s_axi_wvalid && !s_q.w_full) begin
      s_d.w_full = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // the write commits only once the previous response has left
    if (s_q.aw_full && s_q.w_full && !s_q.bvalid) begin
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = is_mapped(s_q.aw_idx) ? apc_pkg::RESP_OKAY : apc_pkg::RESP_SLVERR;
      unique case (s_q.aw_idx)
        apc_pkg::IDX_CTRL_ZERO: s_d.ctrl_zero = apply_strb(s_q.ctrl_zero, s_q.w_data,
                                                           s_q.w_strb); // R2
        apc_pkg::IDX_CTRL_ONE: s_d.ctrl_one = apply_strb(s_q.ctrl_one, s_q.w_data,
                                                         s_q.w_strb); // R2
        apc_pkg::IDX_CTRL_TWO: s_d.ctrl_two = apply_strb(s_q.ctrl_two, s_q.w_data,
                                                         s_q.w_strb); // R2
        default: ;
      endcase
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = apc_pkg::RESP_OKAY;
      unique case (s_axi_araddr[11:2])
        apc_pkg::IDX_CTRL_ZERO: s_d.rdata = s_q.ctrl_zero; // R2
        apc_pkg::IDX_CTRL_ONE: s_d.rdata = s_q.ctrl_one; // R2
        apc_pkg::IDX_CTRL_TWO: s_d.rdata = s_q.ctrl_two; // R2
        default: begin
          s_d.rdata = 32'h0000_0000;
          s_d.rresp = apc_pkg::RESP_SLVERR;
        end
      endcase
    end
    // mode entry overrides a same-cycle write; later writes act normally
    if (sleep_entry) begin
      s_d.ctrl_zero[apc_pkg::BIT_RC_CLOCK_POWERDOWN] = 1'b1; // R6 R18
      s_d.ctrl_zero[apc_pkg::BIT_BIAS_ENABLE] = 1'b0; // R10
      s_d.ctrl_zero[apc_pkg::BIT_REFERENCE_ENABLE] = 1'b0; // R13
      s_d.ctrl_zero[apc_pkg::BIT_VOLTAGE_ADC_ENABLE] = 1'b0; // R16
    end else if (detect_entry) begin
      s_d.ctrl_zero[apc_pkg::BIT_RC_CLOCK_POWERDOWN] = 1'b0; // R6 R18
      s_d.ctrl_zero[apc_pkg::BIT_BIAS_ENABLE] = 1'b1; // R10
      s_d.ctrl_zero[apc_pkg::BIT_REFERENCE_ENABLE] = 1'b1; // R13
      s_d.ctrl_zero[apc_pkg::BIT_VOLTAGE_ADC_ENABLE] = 1'b0; // R16
    end
    // the synchronous resets hold the bank at defaults but leave bus handshakes alone
    if (rx_line_reset || soft_reset) begin
      s_d.ctrl_zero = reset_zero(); // R1
      s_d.ctrl_one = apc_pkg::RST_CTRL_ONE; // R1
      s_d.ctrl_two = apc_pkg::RST_CTRL_TWO; // R1
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.bresp <= apc_pkg::RESP_OKAY;
      s_q.rresp <= apc_pkg::RESP_OKAY;
      s_q.ctrl_zero <= reset_zero(); // R1 R9 R12 R14
      s_q.ctrl_one <= apc_pkg::RST_CTRL_ONE; // R1
      s_q.ctrl_two <= apc_pkg::RST_CTRL_TWO; // R1
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign rc_clock_powerdown = s_q.ctrl_zero[apc_pkg::BIT_RC_CLOCK_POWERDOWN]; // R5
  assign bias_enable = s_q.ctrl_zero[apc_pkg::BIT_BIAS_ENABLE]; // R9
  assign reference_enable = s_q.ctrl_zero[apc_pkg::BIT_REFERENCE_ENABLE]; // R12
  assign voltage_adc_enable = s_q.ctrl_zero[apc_pkg::BIT_VOLTAGE_ADC_ENABLE]; // R14
  assign analog_control_one = s_q.ctrl_one;
  assign analog_control_two = s_q.ctrl_two;

endmodule : apc_regs

// ---- apc_pkg.sv ----
// Summary of operation
// (R1) power-on, receive-line and software resets restore every analog control register default
// (R2) every analog control register reads back what it holds and accepts writes
// (R3) software programs the second control register with 0x30000000
// (R4) software keeps bits 31:30 and 25 of the first register at zero
// (R5) bit 29 high powers down the rc clock; its reset level is undefined
// (R6) sleep entry sets the rc clock power-down; detection entry clears it
// (R7) software enables bandgap and bias before clearing the rc clock power-down
// (R8) in metering mode software should leave the rc clock powered down
// (R9) bit 28 enables the global bias circuit; reset value zero
// (R10) sleep entry clears bias enable; detection entry sets it
// (R11) software sets bias enable before enabling any adc or the rc oscillator
// (R12) bit 27 enables the bandgap reference; reset value zero
// (R13) sleep entry clears reference enable; detection entry sets it
// (R14) bit 26 enables the voltage-channel adc; reset value zero
// (R15) software enables the bandgap before the voltage-channel adc
// (R16) sleep or detection entry clears the voltage adc enable
// (R17) software keeps re-checking these registers throughout operation
// (R18) forcing acts in the cycle a mode is entered; later writes act normally
package apc_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // printed offsets are register indices; byte address is four times the index
  localparam logic [9:0] IDX_CTRL_ZERO = 10'h185;
  localparam logic [9:0] IDX_CTRL_ONE = 10'h186;
  localparam logic [9:0] IDX_CTRL_TWO = 10'h187;

  localparam int BIT_RC_CLOCK_POWERDOWN = 29;
  localparam int BIT_BIAS_ENABLE = 28;
  localparam int BIT_REFERENCE_ENABLE = 27;
  localparam int BIT_VOLTAGE_ADC_ENABLE = 26;

  localparam logic [31:0] RST_CTRL_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_CTRL_ONE = 32'h0000_0000;
  localparam logic [31:0] RST_CTRL_TWO = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : apc_pkg

// ---- apc_mode_edge.sv ----
`timescale 1ns/10ps
// turns the two mode levels into one-cycle entry pulses
module apc_mode_edge (
  input wire logic clk,
  input wire logic rst,
  input wire logic sleep_mode,
  input wire logic current_detect_mode,
  output logic sleep_entry,
  output logic detect_entry
);

  typedef struct packed {
    logic sleep;
    logic detect;
  } apc_edge_state_t;

  apc_edge_state_t s_q;
  apc_edge_state_t s_d;

  always_comb begin
    s_d.sleep = sleep_mode;
    s_d.detect = current_detect_mode;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // a mode already active at reset release counts as entered on the first cycle
  assign sleep_entry = sleep_mode & ~s_q.sleep; // R18
  assign detect_entry = current_detect_mode & ~s_q.detect; // R18

endmodule : apc_mode_edge

// ---- apc_regs_assertions.sv ----
`timescale 1ns/10ps
module apc_regs_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic rx_line_reset,
  input wire logic soft_reset,
  input wire logic sleep_mode,
  input wire logic current_detect_mode,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rc_clock_powerdown,
  input wire logic bias_enable,
  input wire logic reference_enable,
  input wire logic voltage_adc_enable,
  input wire logic [31:0] analog_control_one
);
  logic [3:0] o;
  assign o = {rc_clock_powerdown, bias_enable, reference_enable, voltage_adc_enable};
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_slp; $rose(sleep_mode) |=> o == 4'h8; endproperty
  a_slp: assert property (p_slp) else $error("sleep forcing");
  property p_det; $rose(current_detect_mode) && !sleep_mode && !rx_line_reset && !soft_reset
    |=> o == 4'h6; endproperty
  a_det: assert property (p_det) else $error("detect forcing");
  property p_srst; rx_line_reset || soft_reset |=> o == 4'h8 && analog_control_one == 32'h0;
  endproperty
  a_srst: assert property (p_srst) else $error("sync reset");
  property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bh: assert property (p_bh) else $error("bvalid dropped");
  property p_rh; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
  a_rh: assert property (p_rh) else $error("rvalid dropped");
  property p_ar; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_ar: assert property (p_ar) else $error("read answer late");
  // past reset guard: edge detectors restart at zero and may fire with no visible rise
  property p_stb; !$past(rst) && !rx_line_reset && !soft_reset && !$rose(sleep_mode)
    && !$rose(current_detect_mode) ##1 !$rose(s_axi_bvalid) |-> $stable(o); endproperty
  a_stb: assert property (p_stb) else $error("enables moved");
  property p_one; !rx_line_reset && !soft_reset ##1 !$rose(s_axi_bvalid)
    |-> $stable(analog_control_one); endproperty
  a_one: assert property (p_one) else $error("control one moved");
endmodule : apc_regs_chk
bind apc_regs apc_regs_chk u_apc_regs_chk (.*);

// ---- tb_apc_regs.sv ----
`timescale 1ns/10ps
module tb_apc_regs;
  logic clk = 1'b0, rst = 1'b1, rx_line_reset = 1'b0, soft_reset = 1'b0, sleep_mode = 1'b0;
  logic current_detect_mode = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic rc_clock_powerdown, bias_enable, reference_enable, voltage_adc_enable;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, analog_control_one, analog_control_two;
  int err_total = 0, total_checks = 0;
  always #5 clk = ~clk;
  apc_regs u_apc_regs (.*);
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    // ready a cycle late so the slave must hold its response
    s_axi_bready <= 1'b1;
    @(posedge clk);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
  endtask : wr
  task rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    @(posedge clk);
    s_axi_rready <= 1'b0;
    chk("rdata", d, s_axi_rdata);
    chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
  endtask : rd
  // forced bits show one edge after the mode level rises
  task mode(input logic s, input logic c, input logic [3:0] e);
    @(posedge clk);
    sleep_mode <= s;
    current_detect_mode <= c;
    @(posedge clk);
    @(negedge clk);
    chk("enables", {28'h0, e},
      {28'h0, rc_clock_powerdown, bias_enable, reference_enable, voltage_adc_enable});
  endtask : mode
  task pulse(input logic s);
    @(posedge clk);
    soft_reset <= s;
    rx_line_reset <= !s;
    @(posedge clk);
    soft_reset <= 1'b0;
    rx_line_reset <= 1'b0;
  endtask : pulse
  task t_reset;
    rd(12'h614, 32'h2000_0000, 2'h0);
    rd(12'h618, 32'h0, 2'h0);
    rd(12'h61c, 32'h0, 2'h0);
    $display("reset values done");
  endtask : t_reset
  task t_rw;
    wr(12'h614, 32'h3c00_0000, 2'h0);
    wr(12'h614, 32'h1c00_0000, 2'h0);
    rd(12'h614, 32'h1c00_0000, 2'h0);
    wr(12'h618, 32'h3000_0000, 2'h0);
    chk("control one", 32'h3000_0000, analog_control_one);
    rd(12'h618, 32'h3000_0000, 2'h0);
    wr(12'h61c, 32'ha5a5_5a5a, 2'h0);
    chk("control two", 32'ha5a5_5a5a, analog_control_two);
    rd(12'h61c, 32'ha5a5_5a5a, 2'h0);
    s_axi_wstrb <= 4'h3;
    wr(12'h61c, 32'hffff_ffff, 2'h0);
    s_axi_wstrb <= 4'hf;
    chk("control two", 32'ha5a5_ffff, analog_control_two);
    rd(12'h61c, 32'ha5a5_ffff, 2'h0);
    wr(12'h620, 32'hffff_ffff, 2'h2);
    rd(12'h620, 32'h0, 2'h2);
    $display("read write done");
  endtask : t_rw
  task t_mode;
    mode(1'b1, 1'b0, 4'h8);
    wr(12'h614, 32'h2400_0000, 2'h0);
    rd(12'h614, 32'h2400_0000, 2'h0);
    mode(1'b0, 1'b1, 4'h6);
    rd(12'h614, 32'h1800_0000, 2'h0);
    mode(1'b0, 1'b0, 4'h6);
    mode(1'b1, 1'b1, 4'h8);
    mode(1'b0, 1'b0, 4'h8);
    $display("mode forcing done");
  endtask : t_mode
  // mid-run power-on reset, released with detection mode already high
  task t_por;
    @(posedge clk);
    rst <= 1'b1;
    current_detect_mode <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk("enables", 32'h0000_0006,
      {28'h0, rc_clock_powerdown, bias_enable, reference_enable, voltage_adc_enable});
    chk("control one", 32'h0, analog_control_one);
    chk("control two", 32'h0, analog_control_two);
    rd(12'h614, 32'h1800_0000, 2'h0);
    @(posedge clk);
    current_detect_mode <= 1'b0;
    $display("power-on reset done");
  endtask : t_por
  task t_sync;
    pulse(1'b1);
    rd(12'h614, 32'h2000_0000, 2'h0);
    rd(12'h618, 32'h0, 2'h0);
    chk("control one", 32'h0, analog_control_one);
    wr(12'h61c, 32'h0000_00ff, 2'h0);
    chk("control two", 32'h0000_00ff, analog_control_two);
    pulse(1'b0);
    rd(12'h61c, 32'h0, 2'h0);
    chk("control two", 32'h0, analog_control_two);
    $display("sync resets done");
  endtask : t_sync
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_rw();
    t_por();
    t_mode();
    t_sync();
    test_done();
  end
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    test_done();
  end
endmodule : tb_apc_regs
